// ---- tb/ctrl_model.sv ----
// Controller model issuing register commands to the block
`timescale 1ns/1ps
module ctrl_model (
  input wire logic ref_clk_i, // Bench clock
  input wire status_pkg::rsp_type rsp_i, // Read answer from the block
  output logic cmd_valid_o, // Command strobe
  output status_pkg::cmd_type cmd_o // Command fields
);
  // Idle at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // One command, launched just after an edge, answer taken one edge later
  task automatic issue(input logic wr, input status_pkg::group_type g, input status_pkg::reg_sel_type s,
                       input logic [15:0] d, output status_pkg::rsp_type r);
    @(posedge ref_clk_i);
    #1;
    cmd_o = '{wr, g, s, d};
    cmd_valid_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    r = rsp_i;
    cmd_valid_o = 1'b0;
    // Released data field carries junk, not the last word
    cmd_o.data = ~cmd_o.data;
  endtask
endmodule

// ---- tb/status_event_reporting_test.sv ----
// Self-checking bench for the status event reporting block
`timescale 1ns/1ps
module status_event_reporting_test;
  localparam status_pkg::group_type qg = status_pkg::GRP_QUALITY; // Group shorthands
  localparam status_pkg::group_type ag = status_pkg::GRP_ACTIVITY;
  logic ref_clk; // Bench clock
  logic rst_n; // Reset, active low
  logic [15:0] qual_cond; // Live quality conditions
  logic [15:0] act_cond; // Live activity conditions
  logic cmd_valid; // Command strobe
  status_pkg::cmd_type cmd; // Command fields
  status_pkg::rsp_type rsp; // Read answer
  status_pkg::rsp_type rd; // Last answer taken
  logic [7:0] stb; // Status byte
  logic srq; // Service request
  int n_errors = 0;
  int n_tests = 0;
  status_event_reporting status_event_reporting_inst (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .quality_cond_i(qual_cond), .activity_cond_i(act_cond), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .rsp_o(rsp), .status_byte_o(stb), .srq_o(srq));
  ctrl_model ctrl_model_inst (.ref_clk_i(ref_clk), .rsp_i(rsp), .cmd_valid_o(cmd_valid), .cmd_o(cmd));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Register write
  task automatic wr(input status_pkg::group_type g, input status_pkg::reg_sel_type s, input logic [15:0] d);
    ctrl_model_inst.issue(1'b1, g, s, d, rd);
  endtask
  // Register read, answer must be flagged valid
  task automatic rd_chk(input status_pkg::group_type g, input status_pkg::reg_sel_type s, input logic [15:0] e);
    ctrl_model_inst.issue(1'b0, g, s, 16'h0000, rd);
    check(rd, {1'b1, e});
  endtask
  // Wait edges, land just after the last
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Status byte and request together
  task automatic out_chk(input logic [7:0] e);
    check({9'h000, stb}, {9'h000, e});
    check({16'h0000, srq}, {16'h0000, e[6]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Filter and mask values after reset
  task automatic s_reset();
    rd_chk(qg, status_pkg::SEL_RISE, 16'h1e01);
    rd_chk(ag, status_pkg::SEL_RISE, 16'h1f10);
    rd_chk(qg, status_pkg::SEL_FALL, 16'h0000);
    rd_chk(ag, status_pkg::SEL_MASK, 16'h0000);
    out_chk(8'h00);
  endtask
  // Masked quality event, then enabled timing loss up to the request
  task automatic s_quality();
    wr(qg, status_pkg::SEL_MASK, 16'h0200);
    wr(qg, status_pkg::SEL_SRE, 16'h0008);
    qual_cond = 16'h0001;
    tick(3);
    out_chk(8'h00);
    qual_cond = 16'h0201;
    tick(2);
    out_chk(8'h08);
    tick(1);
    out_chk(8'h48);
    rd_chk(qg, status_pkg::SEL_COND, 16'h0201);
    rd_chk(qg, status_pkg::SEL_EVENT, 16'h0201);
    rd_chk(qg, status_pkg::SEL_EVENT, 16'h0000);
    tick(2);
    out_chk(8'h00);
    qual_cond = 16'h0000;
  endtask
  // Period end raises the activity summary and the request
  task automatic s_activity();
    wr(ag, status_pkg::SEL_MASK, 16'h0200);
    wr(ag, status_pkg::SEL_SRE, 16'h0080);
    act_cond = 16'h0200;
    tick(3);
    out_chk(8'hc0);
    rd_chk(ag, status_pkg::SEL_SRE, 16'h0080);
    rd_chk(ag, status_pkg::SEL_STB, 16'h00c0);
    rd_chk(ag, status_pkg::SEL_EVENT, 16'h0200);
    act_cond = 16'h0000;
    tick(2);
    out_chk(8'h00);
  endtask
  // Falling only on quality, both edges on activity
  task automatic s_edges();
    wr(qg, status_pkg::SEL_RISE, 16'h0000);
    wr(qg, status_pkg::SEL_FALL, 16'h0400);
    wr(ag, status_pkg::SEL_FALL, 16'h0010);
    qual_cond = 16'h0400;
    act_cond = 16'h0010;
    tick(2);
    rd_chk(qg, status_pkg::SEL_EVENT, 16'h0000);
    rd_chk(ag, status_pkg::SEL_EVENT, 16'h0010);
    qual_cond = 16'h0000;
    act_cond = 16'h0000;
    tick(2);
    rd_chk(qg, status_pkg::SEL_EVENT, 16'h0400);
    rd_chk(ag, status_pkg::SEL_EVENT, 16'h0010);
  endtask
  // Unused positions read zero and ignore writes
  task automatic s_unused();
    wr(qg, status_pkg::SEL_MASK, 16'hffff);
    rd_chk(qg, status_pkg::SEL_MASK, 16'h1e01);
    wr(ag, status_pkg::SEL_FALL, 16'hffff);
    rd_chk(ag, status_pkg::SEL_FALL, 16'h1f10);
    qual_cond = 16'hffff;
    act_cond = 16'hffff;
    tick(1);
    rd_chk(qg, status_pkg::SEL_COND, 16'h1e01);
    rd_chk(ag, status_pkg::SEL_COND, 16'h1f10);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic summarize();
    if (n_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    qual_cond = 16'h0000;
    act_cond = 16'h0000;
    repeat (20) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    s_reset();
    s_quality();
    s_activity();
    s_edges();
    s_unused();
    summarize();
  end
  // Watchdog against a hang
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
endmodule

// ---- verilog/status_consts.svh ----
// Constants for the status event reporting block
`ifndef STATUS_CONSTS_SVH
`define STATUS_CONSTS_SVH
// Meaningful flag positions of each group
`define QUAL_VALID_MASK 16'h1e01
`define ACT_VALID_MASK 16'h1f10
// Signal quality flag positions
`define QUAL_DATA_LOSS_BIT 0
`define QUAL_TIMING_LOSS_BIT 9
`define QUAL_LOCK_LOSS_BIT 10
`define QUAL_UNAVAIL_BIT 11
`define QUAL_FIRST_LOCK_BIT 12
// Measurement activity flag positions
`define ACT_GATING_BIT 4
`define ACT_BIT_ERROR_BIT 8
`define ACT_PERIOD_DONE_BIT 9
`define ACT_LOGGING_BIT 10
`define ACT_SKEW_SEARCH_BIT 11
`define ACT_TUNING_BIT 12
// Status byte layout
`define STB_QUAL_BIT 3
`define STB_RQS_BIT 6
`define STB_ACT_BIT 7
// Reset values
`define FALL_RESET 16'h0000
`define MASK_RESET 16'h0000
`define SRE_RESET 8'h00
`endif

// ---- verilog/status_event_reporting.sv ----
// Status event reporting: two register groups, status byte and service request
// Operation
// - Quality group is 16 bits, documented flags only
// - Quality flags at 1, 512, 1024, 2048, 4096
// - Enable mask gates events onto summary bit
// - Enabled quality event sets status byte bit 3
// - Rising, falling or both edges latch, per bit
// - After reset filters pass rising edges only
// - Activity group is 16 bits, six flags used
// - Period end at bit 9, logging at 10
// - Skew search at 11, tuning at 12
// - Enabled period-done event sets activity summary
// - Condition and event readable per group
// - Enabled summary bit raises service request
// - Activity summary sits at status byte bit 7
// - Reading an event register clears it to the edges passed in that same cycle
`timescale 1ns/1ps
`include "status_consts.svh"

module status_event_reporting #(
  parameter int DATA_W = 16 // Register width
) (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic rst_n_i, // Asynchronous reset, active low
  input wire logic [15:0] quality_cond_i, // Live quality conditions, same clock
  input wire logic [15:0] activity_cond_i, // Live activity conditions, same clock
  input wire logic cmd_valid_i, // Command strobe, one cycle
  input wire status_pkg::cmd_type cmd_i, // Command fields
  output status_pkg::rsp_type rsp_o, // Read answer, registered
  output logic [7:0] status_byte_o, // Status byte, registered bits
  output logic srq_o // Service request, level
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (DATA_W != 16) begin : g_bad_width
    $error("status_event_reporting serves 16-bit groups only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  localparam logic [15:0] VALID [2] = '{`QUAL_VALID_MASK, `ACT_VALID_MASK}; // Used positions
  logic [15:0] cond [2]; // Live conditions per group
  logic [15:0] prev_reg [2]; // Conditions one cycle ago
  logic [15:0] event_reg [2]; // Latched events
  logic [15:0] rise_reg [2]; // rising_pass_mask per group
  logic [15:0] fall_reg [2]; // falling_pass_mask per group
  logic [15:0] mask_reg [2]; // Event enable mask per group
  logic [15:0] hit [2]; // Edges passed by the filter this cycle
  logic [1:0] summary_reg; // quality and activity summary bits
  logic [7:0] sre_reg; // Service request enable
  logic srq_reg; // Service request state
  status_pkg::rsp_type rsp_reg; // Read answer
  logic [7:0] stb; // Assembled status byte

  assign cond[0] = quality_cond_i & VALID[0];
  assign cond[1] = activity_cond_i & VALID[1];

  ////////////////////////////////////////////////////////////////////////////
  // Per-group logic
  for (genvar g = 0; g < 2; g++) begin : g_grp
    logic sel_grp; // Command aimed at this group
    logic wr_hit; // Write strobe for this group
    logic rd_event; // Event read of this group

    assign sel_grp = cmd_valid_i && (int'(cmd_i.grp) == g);
    assign wr_hit = sel_grp && cmd_i.wr;
    assign rd_event = sel_grp && !cmd_i.wr && (cmd_i.sel == status_pkg::SEL_EVENT);

    // Filter: pass rising and falling edges per bit
    assign hit[g] = (rise_reg[g] & cond[g] & ~prev_reg[g]) | (fall_reg[g] & ~cond[g] & prev_reg[g]);

    // Previous condition for edge detection
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        prev_reg[g] <= 16'h0000;
      end else begin
        prev_reg[g] <= cond[g];
      end
    end

    // Event latch: a new edge wins over a read clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        event_reg[g] <= 16'h0000;
      end else if (rd_event) begin
        event_reg[g] <= hit[g];
      end else begin
        event_reg[g] <= event_reg[g] | hit[g];
      end
    end

    // Rising filter, passes all used bits after reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        rise_reg[g] <= VALID[g];
      end else if (wr_hit && cmd_i.sel == status_pkg::SEL_RISE) begin
        rise_reg[g] <= cmd_i.data & VALID[g];
      end
    end

    // Falling filter, closed after reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        fall_reg[g] <= `FALL_RESET;
      end else if (wr_hit && cmd_i.sel == status_pkg::SEL_FALL) begin
        fall_reg[g] <= cmd_i.data & VALID[g];
      end
    end

    // Event enable mask
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mask_reg[g] <= `MASK_RESET;
      end else if (wr_hit && cmd_i.sel == status_pkg::SEL_MASK) begin
        mask_reg[g] <= cmd_i.data & VALID[g];
      end
    end

    // Summary bit from masked events
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        summary_reg[g] <= 1'b0;
      end else begin
        summary_reg[g] <= |(event_reg[g] & mask_reg[g]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte and service request
  always_comb begin
    stb = 8'h00;
    stb[`STB_QUAL_BIT] = summary_reg[0];
    stb[`STB_ACT_BIT] = summary_reg[1];
    stb[`STB_RQS_BIT] = srq_reg;
  end

  // Service request enable register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sre_reg <= `SRE_RESET;
    end else if (cmd_valid_i && cmd_i.wr && cmd_i.sel == status_pkg::SEL_SRE) begin
      sre_reg <= cmd_i.data[7:0];
    end
  end

  // Request while any enabled summary bit stands
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      srq_reg <= 1'b0;
    end else begin
      srq_reg <= |(stb & sre_reg & ~(8'h01 << `STB_RQS_BIT));
    end
  end

  assign srq_o = srq_reg;
  assign status_byte_o = stb;

  ////////////////////////////////////////////////////////////////////////////
  // Read answer, one cycle after the command
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.valid <= cmd_valid_i && !cmd_i.wr;
      if (cmd_valid_i && !cmd_i.wr) begin
        case (cmd_i.sel)
          status_pkg::SEL_COND: rsp_reg.data <= cond[cmd_i.grp];
          status_pkg::SEL_EVENT: rsp_reg.data <= event_reg[cmd_i.grp];
          status_pkg::SEL_RISE: rsp_reg.data <= rise_reg[cmd_i.grp];
          status_pkg::SEL_FALL: rsp_reg.data <= fall_reg[cmd_i.grp];
          status_pkg::SEL_MASK: rsp_reg.data <= mask_reg[cmd_i.grp];
          status_pkg::SEL_STB: rsp_reg.data <= {8'h00, stb};
          status_pkg::SEL_SRE: rsp_reg.data <= {8'h00, sre_reg};
          default: rsp_reg.data <= 16'h0000;
        endcase
      end
    end
  end

  assign rsp_o = rsp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Timing loss rising with filter open
  sequence s_timing_low;
    !quality_cond_i[`QUAL_TIMING_LOSS_BIT];
  endsequence
  sequence s_timing_rise;
    s_timing_low ##1 (quality_cond_i[`QUAL_TIMING_LOSS_BIT] && rise_reg[0][`QUAL_TIMING_LOSS_BIT]);
  endsequence
  // Gating falling with filter open
  sequence s_gating_fall;
    activity_cond_i[`ACT_GATING_BIT] ##1
      (!activity_cond_i[`ACT_GATING_BIT] && fall_reg[1][`ACT_GATING_BIT]);
  endsequence

  a_rise_latch: assert property (s_timing_rise |=> event_reg[0][`QUAL_TIMING_LOSS_BIT])
    else $error("rising edge not latched");
  a_fall_latch: assert property (s_gating_fall |=> event_reg[1][`ACT_GATING_BIT])
    else $error("falling edge not latched");
  a_quality_summary: assert property ((event_reg[0][`QUAL_TIMING_LOSS_BIT] && mask_reg[0][`QUAL_TIMING_LOSS_BIT])
    |=> status_byte_o[`STB_QUAL_BIT])
    else $error("quality summary not set");
  a_activity_summary: assert property ((event_reg[1][`ACT_PERIOD_DONE_BIT] && mask_reg[1][`ACT_PERIOD_DONE_BIT])
    |=> status_byte_o[`STB_ACT_BIT])
    else $error("activity summary not set");
  a_mask_blocks: assert property ((event_reg[1] & mask_reg[1]) == 16'h0000 |=> !status_byte_o[`STB_ACT_BIT])
    else $error("summary set without enabled event");
  a_srq_raise: assert property ((status_byte_o[`STB_ACT_BIT] && sre_reg[`STB_ACT_BIT]) |=> srq_o)
    else $error("service request missing");
  a_read_clear: assert property ((cmd_valid_i && !cmd_i.wr && cmd_i.sel == status_pkg::SEL_EVENT
    && cmd_i.grp == status_pkg::GRP_QUALITY && hit[0] == 16'h0000) |=> event_reg[0] == 16'h0000)
    else $error("event read did not clear");
  a_cond_read: assert property ((cmd_valid_i && !cmd_i.wr && cmd_i.sel == status_pkg::SEL_COND)
    |=> rsp_o.valid && rsp_o.data == $past((cmd_i.grp == status_pkg::GRP_ACTIVITY) ? cond[1] : cond[0]))
    else $error("condition read wrong");
  a_unused_zero: assert property (((event_reg[0] | rise_reg[0] | fall_reg[0] | mask_reg[0]) & ~`QUAL_VALID_MASK) == 16'h0000
    && ((event_reg[1] | rise_reg[1] | fall_reg[1] | mask_reg[1]) & ~`ACT_VALID_MASK) == 16'h0000)
    else $error("unused bit set");
  a_reset_filter: assert property ($rose(rst_n_i) |-> rise_reg[1] == `ACT_VALID_MASK && fall_reg[1] == 16'h0000)
    else $error("filters not at reset value");

  // Quality group filters and mask just after reset release
  a_reset_quality: assert property ($rose(rst_n_i) |-> rise_reg[0] == `QUAL_VALID_MASK
    && fall_reg[0] == `FALL_RESET && mask_reg[0] == `MASK_RESET)
    else $error("quality filters not at reset value");

  // Period done rising with the filter open
  sequence s_period_low;
    !activity_cond_i[`ACT_PERIOD_DONE_BIT];
  endsequence
  sequence s_period_rise;
    s_period_low ##1 (activity_cond_i[`ACT_PERIOD_DONE_BIT] && rise_reg[1][`ACT_PERIOD_DONE_BIT]);
  endsequence

  // Period done edge must reach the activity event register
  a_period_latch: assert property (s_period_rise |=> event_reg[1][`ACT_PERIOD_DONE_BIT])
    else $error("period done edge not latched");

  // Quality summary also raises the request when enabled
  a_srq_quality: assert property ((status_byte_o[`STB_QUAL_BIT] && sre_reg[`STB_QUAL_BIT]) |=> srq_o)
    else $error("quality service request missing");

  // No enabled summary bit, no request one cycle later
  a_srq_idle: assert property (((status_byte_o & sre_reg & ~(8'h01 << `STB_RQS_BIT)) == 8'h00) |=> !srq_o)
    else $error("service request without enabled summary");

  // Request bit of the status byte mirrors the request line
  a_stb_mirror: assert property (status_byte_o[`STB_RQS_BIT] == srq_o)
    else $error("status byte request bit differs from line");

  // Only the two summary bits and the request bit may be set
  a_stb_unused: assert property ((status_byte_o & ~((8'h01 << `STB_QUAL_BIT) | (8'h01 << `STB_RQS_BIT)
    | (8'h01 << `STB_ACT_BIT))) == 8'h00)
    else $error("unused status byte bit set");

  // Quality summary follows masked events one cycle later
  a_quality_follow: assert property (status_byte_o[`STB_QUAL_BIT] == $past(|(event_reg[0] & mask_reg[0])))
    else $error("quality summary does not follow events");

  // Activity summary follows masked events one cycle later
  a_activity_follow: assert property (status_byte_o[`STB_ACT_BIT] == $past(|(event_reg[1] & mask_reg[1])))
    else $error("activity summary does not follow events");

  // Every read gets exactly one answer pulse, one cycle later
  a_rsp_valid: assert property (rsp_o.valid == $past(cmd_valid_i && !cmd_i.wr))
    else $error("read answer pulse wrong");

  // Event read returns the latched events of the chosen group
  a_event_read: assert property ((cmd_valid_i && !cmd_i.wr && cmd_i.sel == status_pkg::SEL_EVENT)
    |=> rsp_o.data == $past((cmd_i.grp == status_pkg::GRP_ACTIVITY) ? event_reg[1] : event_reg[0]))
    else $error("event read wrong");

  // Activity event read with no new edge leaves it empty
  a_act_read_clear: assert property ((cmd_valid_i && !cmd_i.wr && cmd_i.sel == status_pkg::SEL_EVENT
    && cmd_i.grp == status_pkg::GRP_ACTIVITY && hit[1] == 16'h0000) |=> event_reg[1] == 16'h0000)
    else $error("activity event read did not clear");

  // Filters change only through a write command
  a_filter_hold: assert property (!(cmd_valid_i && cmd_i.wr)
    |=> $stable(rise_reg[0]) && $stable(fall_reg[0]) && $stable(rise_reg[1]) && $stable(fall_reg[1]))
    else $error("filter changed without write");

endmodule

// ---- verilog/status_pkg.sv ----
// Types for the status event reporting block
package status_pkg;
  // Register selected by a command
  typedef enum logic [2:0] {
    SEL_COND,
    SEL_EVENT,
    SEL_RISE,
    SEL_FALL,
    SEL_MASK,
    SEL_STB,
    SEL_SRE
  } reg_sel_type;
  // Group selected by a command
  typedef enum logic {
    GRP_QUALITY,
    GRP_ACTIVITY
  } group_type;
  // One register command from the controller side
  typedef struct packed {
    logic wr;
    group_type grp;
    reg_sel_type sel;
    logic [15:0] data;
  } cmd_type;
  // Read answer
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } rsp_type;
endpackage
